// ### rtl/capture_compare_params.svh
// register indices, field positions, reset values and mode codes
// assumes: included by bare name; definitions only
`ifndef CAPTURE_COMPARE_PARAMS_SVH
`define CAPTURE_COMPARE_PARAMS_SVH

// ----------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------
`define IDX_FLAGS_ONE 8'h0C
`define IDX_FLAGS_TWO 8'h0D
`define IDX_TIMER_LOW 8'h0E
`define IDX_TIMER_HIGH 8'h0F
`define IDX_TIMER_CONTROL 8'h10
`define IDX_VALUE_LOW 8'h15
`define IDX_VALUE_HIGH 8'h16
`define IDX_UNIT_CONTROL 8'h17
`define IDX_ENABLES_ONE 8'h8C

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_TIMER_OVERFLOW 0
`define BIT_UNIT_EVENT 2
`define BIT_SECOND_EVENT 0
`define BIT_BUS_COLLISION 3
`define BIT_LOW_VOLTAGE 7
`define BIT_TIMER_ON 0

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define UNIT_CONTROL_MASK 8'h3F
`define TIMER_CONTROL_MASK 8'h3F
`define TIMER_TOP 16'hFFFF

// ----------------------------------------
// unit mode field codes
// ----------------------------------------
`define MODE_OFF 4'h0
`define MODE_CAPTURE_FALL 4'h4
`define MODE_CAPTURE_RISE 4'h5
`define MODE_CAPTURE_RISE4 4'h6
`define MODE_CAPTURE_RISE16 4'h7
`define MODE_COMPARE_HIGH 4'h8
`define MODE_COMPARE_LOW 4'h9
`define MODE_COMPARE_SOFT 4'hA
`define MODE_COMPARE_TRIGGER 4'hB
`define PRESCALE_FOURTH_MASK 4'h3
`define PRESCALE_SIXTEENTH 4'hF

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### rtl/capture_compare_pkg.sv
// types shared by the capture/compare unit
// assumes: the params header is on the include path
`include "capture_compare_params.svh"

package capture_compare_pkg;

  // ----------------------------------------
  // unit mode field
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = `MODE_OFF,
    MODE_CAPTURE_FALL = `MODE_CAPTURE_FALL,
    MODE_CAPTURE_RISE = `MODE_CAPTURE_RISE,
    MODE_CAPTURE_RISE4 = `MODE_CAPTURE_RISE4,
    MODE_CAPTURE_RISE16 = `MODE_CAPTURE_RISE16,
    MODE_COMPARE_HIGH = `MODE_COMPARE_HIGH,
    MODE_COMPARE_LOW = `MODE_COMPARE_LOW,
    MODE_COMPARE_SOFT = `MODE_COMPARE_SOFT,
    MODE_COMPARE_TRIGGER = `MODE_COMPARE_TRIGGER
  } unit_mode_e;

endpackage : capture_compare_pkg

// ### rtl/capture_compare_unit.sv
// capture/compare unit with its timer, flag registers and AXI4-Lite slave
// assumes: one clock aclk, synchronous active-low reset; unit pin is a two-way pin
//
// Notes on behaviour
// - capture copies whole timer into value register
// - mode field picks falling, rising, 4th, 16th
// - capture sets unit event flag until cleared
// - new capture overwrites old value silently
// - port write on output pin may capture
// - prescaler cleared when off or not capturing
// - prescaler switch keeps count; software writes zero
// - compare match drives pin high, low, unchanged
// - compare match sets unit event flag too
// - writing zero to control forces latch low
// - software compare mode leaves pin alone
// - first unit trigger resets timer count
// - second trigger resets timer, starts conversion
// - second trigger reset never sets overflow flag
// - flags set regardless of enable bits
// - second flag register bits 7, 3, 0
`timescale 1ns/1ps
`include "capture_compare_params.svh"

module capture_compare_unit
  import capture_compare_pkg::*;
#(
  parameter int ADDR_WIDTH = 10,
  parameter int TIMER_WIDTH = 16
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe,
  input wire logic port_c_direction,
  input wire logic port_data,
  input wire logic second_unit_trigger,
  input wire logic second_unit_event,
  input wire logic adc_enabled,
  output logic adc_start,
  input wire logic low_voltage_event,
  input wire logic bus_collision_event,
  output logic [7:0] peripheral_enables
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [7:0] peripheral_flags_one;
  logic [7:0] peripheral_flags_two;
  logic [TIMER_WIDTH-1:0] timer_one_count;
  logic [7:0] timer_one_control;
  logic [TIMER_WIDTH-1:0] capture_compare_value;
  logic [7:0] unit_control;
  logic [7:0] peripheral_enables_one;
  logic sync_one;
  logic sync_two;
  logic sync_three;
  logic pin_level;
  logic pin_prev;
  logic pin_rise;
  logic pin_fall;
  logic [3:0] prescale_count;
  logic capture_mode;
  logic compare_mode;
  logic capture_event;
  logic match_now;
  logic match_prev;
  logic compare_event;
  logic unit_trigger;
  logic timer_clear;
  logic timer_on;
  logic timer_overflow;
  logic compare_latch;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wr_index;
  logic [7:0] rd_index;
  logic [7:0] wr_byte;
  logic wr_byte_en;
  logic wr_mapped;
  logic rd_mapped;
  logic [7:0] rd_byte;
  unit_mode_e unit_mode;

  // ----------------------------------------
  // bus handshake and address decode
  // ----------------------------------------
  // write address and data are taken together, one write in flight
  assign wr_fire = awvalid && wvalid && !bvalid;
  assign awready = wr_fire;
  assign wready = wr_fire;
  assign rd_fire = arvalid && !rvalid;
  assign arready = !rvalid;
  assign wr_index = awaddr[9:2];
  assign rd_index = araddr[9:2];
  assign wr_byte = wdata[7:0];
  assign wr_byte_en = wr_fire && wstrb[0];

  // decode of mapped register indices
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `IDX_FLAGS_ONE) || (idx == `IDX_FLAGS_TWO) || (idx == `IDX_TIMER_LOW) ||
                (idx == `IDX_TIMER_HIGH) || (idx == `IDX_TIMER_CONTROL) || (idx == `IDX_VALUE_LOW) ||
                (idx == `IDX_VALUE_HIGH) || (idx == `IDX_UNIT_CONTROL) || (idx == `IDX_ENABLES_ONE);
  endfunction : is_mapped

  assign wr_mapped = is_mapped(wr_index);
  assign rd_mapped = is_mapped(rd_index);

  // write response, held until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // read multiplexer; bits above the register byte read as zero
  always_comb
  begin
    unique case (rd_index)
      `IDX_FLAGS_ONE: rd_byte = peripheral_flags_one;
      `IDX_FLAGS_TWO: rd_byte = peripheral_flags_two;
      `IDX_TIMER_LOW: rd_byte = timer_one_count[7:0];
      `IDX_TIMER_HIGH: rd_byte = timer_one_count[15:8];
      `IDX_TIMER_CONTROL: rd_byte = timer_one_control;
      `IDX_VALUE_LOW: rd_byte = capture_compare_value[7:0];
      `IDX_VALUE_HIGH: rd_byte = capture_compare_value[15:8];
      `IDX_UNIT_CONTROL: rd_byte = unit_control;
      `IDX_ENABLES_ONE: rd_byte = peripheral_enables_one;
      default: rd_byte = `RESET_BYTE;
    endcase
  end

  // read data, registered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, rd_byte};
      rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // unit control; the mode field steers capture and compare
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      unit_control <= `RESET_BYTE;
    end
    else if (wr_byte_en && wr_index == `IDX_UNIT_CONTROL)
    begin
      unit_control <= wr_byte & `UNIT_CONTROL_MASK;
    end
  end

  // timer control and enables; only the run bit acts here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_one_control <= `RESET_BYTE;
      peripheral_enables_one <= `RESET_BYTE;
    end
    else if (wr_byte_en)
    begin
      if (wr_index == `IDX_TIMER_CONTROL)
        timer_one_control <= wr_byte & `TIMER_CONTROL_MASK;
      if (wr_index == `IDX_ENABLES_ONE)
        peripheral_enables_one <= wr_byte;
    end
  end

  assign peripheral_enables = peripheral_enables_one;
  assign unit_mode = unit_mode_e'(unit_control[3:0]);
  assign capture_mode = (unit_control[3:2] == 2'b01);
  assign compare_mode = (unit_control[3:2] == 2'b10);
  assign timer_on = timer_one_control[`BIT_TIMER_ON];

  // ----------------------------------------
  // pin synchroniser and edge detection
  // ----------------------------------------
  // a level change counts once the second and third stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_one <= 1'b0;
      sync_two <= 1'b0;
      sync_three <= 1'b0;
      pin_level <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      sync_one <= unit_pin_in;
      sync_two <= sync_one;
      sync_three <= sync_two;
      if (sync_two == sync_three)
        pin_level <= sync_three;
      pin_prev <= pin_level;
    end
  end

  assign pin_rise = pin_level && !pin_prev;
  assign pin_fall = !pin_level && pin_prev;

  // ----------------------------------------
  // capture prescaler and event selection
  // ----------------------------------------
  // counts rising edges; a switch between capture settings keeps the count
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !capture_mode)
    begin
      prescale_count <= 4'h0;
    end
    else if (pin_rise)
    begin
      prescale_count <= prescale_count + 4'h1;
    end
  end

  // capture event from the selected edge choice
  always_comb
  begin
    unique case (unit_mode)
      MODE_CAPTURE_FALL: capture_event = pin_fall;
      MODE_CAPTURE_RISE: capture_event = pin_rise;
      MODE_CAPTURE_RISE4: capture_event = pin_rise &&
        ((prescale_count & `PRESCALE_FOURTH_MASK) == `PRESCALE_FOURTH_MASK);
      MODE_CAPTURE_RISE16: capture_event = pin_rise && (prescale_count == `PRESCALE_SIXTEENTH);
      default: capture_event = 1'b0;
    endcase
  end

  // ----------------------------------------
  // compare and special event trigger
  // ----------------------------------------
  assign match_now = compare_mode && (timer_one_count == capture_compare_value);
  assign compare_event = match_now && !match_prev;
  assign unit_trigger = compare_event && (unit_mode == MODE_COMPARE_TRIGGER);
  assign timer_clear = unit_trigger || second_unit_trigger;

  // one event per match, even while the timer stands still
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      match_prev <= 1'b0;
    else
      match_prev <= match_now;
  end

  // conversion start pulse from the second unit trigger
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adc_start <= 1'b0;
    else
      adc_start <= second_unit_trigger && adc_enabled;
  end

  // compare output latch, apart from the port data latch
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_latch <= 1'b0;
    end
    else if (wr_byte_en && wr_index == `IDX_UNIT_CONTROL && wr_byte == `RESET_BYTE)
    begin
      compare_latch <= 1'b0;
    end
    else if (compare_event && unit_mode == MODE_COMPARE_HIGH)
    begin
      compare_latch <= 1'b1;
    end
    else if (compare_event && unit_mode == MODE_COMPARE_LOW)
    begin
      compare_latch <= 1'b0;
    end
  end

  // pin drive: compare latch in compare modes, port data otherwise
  assign unit_pin_out = compare_mode ? compare_latch : port_data;
  assign unit_pin_oe = !port_c_direction;

  // ----------------------------------------
  // timer one count
  // ----------------------------------------
  // wrap only by counting; a trigger clear is never an overflow
  assign timer_overflow = timer_on && (timer_one_count == `TIMER_TOP) && !timer_clear;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_one_count <= `RESET_WORD;
    end
    else if (timer_clear)
    begin
      timer_one_count <= `RESET_WORD;
    end
    else if (wr_byte_en && wr_index == `IDX_TIMER_LOW)
    begin
      timer_one_count[7:0] <= wr_byte;
    end
    else if (wr_byte_en && wr_index == `IDX_TIMER_HIGH)
    begin
      timer_one_count[15:8] <= wr_byte;
    end
    else if (timer_on)
    begin
      timer_one_count <= timer_one_count + 16'h0001;
    end
  end

  // ----------------------------------------
  // capture/compare value
  // ----------------------------------------
  // a capture wins over a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capture_compare_value <= `RESET_WORD;
    end
    else if (capture_event)
    begin
      capture_compare_value <= timer_one_count;
    end
    else if (wr_byte_en && wr_index == `IDX_VALUE_LOW)
    begin
      capture_compare_value[7:0] <= wr_byte;
    end
    else if (wr_byte_en && wr_index == `IDX_VALUE_HIGH)
    begin
      capture_compare_value[15:8] <= wr_byte;
    end
  end

  // ----------------------------------------
  // flag registers
  // ----------------------------------------
  // hardware set wins over a software write; enables play no part
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      peripheral_flags_one <= `RESET_BYTE;
    end
    else
    begin
      if (wr_byte_en && wr_index == `IDX_FLAGS_ONE)
      begin
        peripheral_flags_one[`BIT_UNIT_EVENT] <= wr_byte[`BIT_UNIT_EVENT] || capture_event || compare_event;
        peripheral_flags_one[`BIT_TIMER_OVERFLOW] <= wr_byte[`BIT_TIMER_OVERFLOW] || timer_overflow;
      end
      else
      begin
        if (capture_event || compare_event)
          peripheral_flags_one[`BIT_UNIT_EVENT] <= 1'b1;
        if (timer_overflow)
          peripheral_flags_one[`BIT_TIMER_OVERFLOW] <= 1'b1;
      end
    end
  end

  // second flag register; unlisted bits stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      peripheral_flags_two <= `RESET_BYTE;
    end
    else if (wr_byte_en && wr_index == `IDX_FLAGS_TWO)
    begin
      peripheral_flags_two[`BIT_LOW_VOLTAGE] <= wr_byte[`BIT_LOW_VOLTAGE] || low_voltage_event;
      peripheral_flags_two[`BIT_BUS_COLLISION] <= wr_byte[`BIT_BUS_COLLISION] || bus_collision_event;
      peripheral_flags_two[`BIT_SECOND_EVENT] <= wr_byte[`BIT_SECOND_EVENT] || second_unit_event;
    end
    else
    begin
      if (low_voltage_event)
        peripheral_flags_two[`BIT_LOW_VOLTAGE] <= 1'b1;
      if (bus_collision_event)
        peripheral_flags_two[`BIT_BUS_COLLISION] <= 1'b1;
      if (second_unit_event)
        peripheral_flags_two[`BIT_SECOND_EVENT] <= 1'b1;
    end
  end

endmodule : capture_compare_unit

// ### verif/capture_compare_unit_properties.sv
// concurrent checks on the capture/compare unit's bus and trigger ports
// assumes: bound to capture_compare_unit; one clock aclk, reset aresetn low
`timescale 1ns/1ps

module cc_properties
#(
  parameter int ADDR_WIDTH = 10
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic unit_pin_oe,
  input wire logic port_c_direction,
  input wire logic second_unit_trigger,
  input wire logic adc_enabled,
  input wire logic adc_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  a_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
    else $error("write not answered next cycle");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped or changed");
  a_bvalid_clear: assert property (bvalid && bready |=> !bvalid)
    else $error("write response outlived handshake");
  a_write_block: assert property (bvalid |-> !awready)
    else $error("write taken while response pending");
  a_write_pair: assert property (wready == awready)
    else $error("write data and address taken apart");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped or changed");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // ----------------------------------------
  // pin and second unit trigger
  // ----------------------------------------
  a_pin_dir: assert property (unit_pin_oe == !port_c_direction)
    else $error("pin enable disagrees with direction");
  a_adc_start: assert property (second_unit_trigger && adc_enabled |=> adc_start)
    else $error("conversion start missing");
  a_adc_cause: assert property (adc_start |-> $past(second_unit_trigger && adc_enabled))
    else $error("conversion start without trigger");
endmodule : cc_properties

bind capture_compare_unit cc_properties #(.ADDR_WIDTH(ADDR_WIDTH)) cc_chk (.*);

// ### verif/capture_compare_unit_test.sv
// self-checking bench for the capture/compare unit
// assumes: the params header is on the include path; timer is stopped while capturing
`timescale 1ns/1ps
`include "capture_compare_params.svh"

module capture_compare_unit_test;
  import capture_compare_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
  logic [9:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic [7:0] peripheral_enables, got;
  logic unit_pin_in, unit_pin_out, unit_pin_oe, port_c_direction, port_data, adc_start;
  logic second_unit_trigger, second_unit_event, adc_enabled, low_voltage_event, bus_collision_event;
  int err_count = 0;
  int tests_run = 0;

  capture_compare_unit uut (.*);
  pin_partner pm (.*);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    got = rdata[7:0];
    last_resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic set_timer(input logic [15:0] t);
    wr(`IDX_TIMER_LOW, t[7:0]);
    wr(`IDX_TIMER_HIGH, t[15:8]);
  endtask : set_timer

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic reset_values();
    rd(`IDX_UNIT_CONTROL); chk(got, 8'h00);
    rd(`IDX_FLAGS_ONE); chk(got, 8'h00);
    rd(`IDX_ENABLES_ONE); chk(got, 8'h00);
    rd(8'hFF); chk({6'h00, last_resp}, 8'h02);
    wr(8'hFF, 8'h55); chk({6'h00, last_resp}, 8'h02);
    wr(`IDX_TIMER_CONTROL, 8'hFE); rd(`IDX_TIMER_CONTROL); chk(got, 8'h3E);
    wr(`IDX_ENABLES_ONE, 8'h04); rd(`IDX_ENABLES_ONE); chk(got, 8'h04);
    chk(peripheral_enables, 8'h04);
    wr(`IDX_TIMER_CONTROL, 8'h00);
  endtask : reset_values

  task automatic cap(input unit_mode_e m, input int pre, input int n, input logic [15:0] t);
    wr(`IDX_UNIT_CONTROL, {4'h0, m});
    pm.pulse(pre);
    wr(`IDX_UNIT_CONTROL, 8'h00);
    wr(`IDX_UNIT_CONTROL, {4'h0, m});
    set_timer(t);
    wr(`IDX_FLAGS_ONE, 8'h00);
    pm.pulse(n - 1);
    rd(`IDX_FLAGS_ONE); chk(got, 8'h00);
    pm.pulse(1);
    rd(`IDX_FLAGS_ONE); chk(got, 8'h04);
    rd(`IDX_VALUE_LOW); chk(got, t[7:0]);
    rd(`IDX_VALUE_HIGH); chk(got, t[15:8]);
  endtask : cap

  task automatic port_capture();
    wr(`IDX_UNIT_CONTROL, {4'h0, MODE_CAPTURE_RISE});
    set_timer(16'h1111);
    pm.pulse(1);
    rd(`IDX_VALUE_HIGH); chk(got, 8'h11);
    set_timer(16'h5A5A);
    port_c_direction <= 1'b0;
    repeat (2) @(posedge aclk);
    port_data <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(`IDX_VALUE_LOW); chk(got, 8'h5A);
    rd(`IDX_VALUE_HIGH); chk(got, 8'h5A);
  endtask : port_capture

  task automatic cmp(input unit_mode_e m, input logic e);
    wr(`IDX_UNIT_CONTROL, {4'h0, m});
    set_timer(16'h011C);
    wr(`IDX_FLAGS_ONE, 8'h00);
    wr(`IDX_TIMER_CONTROL, 8'h01);
    repeat (10) @(posedge aclk);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    chk({7'h00, unit_pin_out}, {7'h00, e});
    rd(`IDX_FLAGS_ONE); chk(got, 8'h04);
  endtask : cmp

  task automatic compares();
    wr(`IDX_VALUE_LOW, 8'h20);
    wr(`IDX_VALUE_HIGH, 8'h01);
    cmp(MODE_COMPARE_HIGH, 1'b1);
    cmp(MODE_COMPARE_SOFT, 1'b1);
    cmp(MODE_COMPARE_LOW, 1'b0);
    cmp(MODE_COMPARE_HIGH, 1'b1);
    wr(`IDX_UNIT_CONTROL, 8'h00);
    wr(`IDX_UNIT_CONTROL, {4'h0, MODE_COMPARE_HIGH});
    chk({7'h00, unit_pin_out}, 8'h00);
    wr(`IDX_UNIT_CONTROL, {4'h0, MODE_COMPARE_TRIGGER});
    set_timer(16'h0118);
    wr(`IDX_TIMER_CONTROL, 8'h01);
    repeat (20) @(posedge aclk);
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rd(`IDX_TIMER_HIGH); chk(got, 8'h00);
  endtask : compares

  task automatic second_unit();
    set_timer(16'hFFF0);
    wr(`IDX_FLAGS_ONE, 8'h00);
    adc_enabled <= 1'b1;
    second_unit_trigger <= 1'b1;
    second_unit_event <= 1'b1;
    low_voltage_event <= 1'b1;
    bus_collision_event <= 1'b1;
    @(posedge aclk);
    second_unit_trigger <= 1'b0;
    second_unit_event <= 1'b0;
    low_voltage_event <= 1'b0;
    bus_collision_event <= 1'b0;
    rd(`IDX_TIMER_LOW); chk(got, 8'h00);
    rd(`IDX_TIMER_HIGH); chk(got, 8'h00);
    rd(`IDX_FLAGS_ONE); chk(got, 8'h00);
    rd(`IDX_FLAGS_TWO); chk(got, 8'h89);
    wr(`IDX_FLAGS_TWO, 8'hFF); rd(`IDX_FLAGS_TWO); chk(got, 8'h89);
    // running timer reaches FFFF exactly as the trigger arrives: cleared, no overflow flag
    set_timer(16'hFF00);
    wr(`IDX_TIMER_CONTROL, 8'h01);
    wr(`IDX_TIMER_LOW, 8'hFE);
    second_unit_trigger <= 1'b1;
    @(posedge aclk);
    second_unit_trigger <= 1'b0;
    wr(`IDX_TIMER_CONTROL, 8'h00);
    rd(`IDX_TIMER_HIGH); chk(got, 8'h00);
    rd(`IDX_FLAGS_ONE); chk(got, 8'h00);
  endtask : second_unit

  // ----------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial
  begin
    #400000;
    err_count++;
    results();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, port_data} = '0;
    {second_unit_trigger, second_unit_event, adc_enabled, low_voltage_event, bus_collision_event} = '0;
    {awaddr, araddr, wdata, awprot, arprot} = '0;
    wstrb = 4'hF;
    port_c_direction = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    reset_values();
    cap(MODE_CAPTURE_FALL, 0, 1, 16'h1401);
    cap(MODE_CAPTURE_RISE, 0, 1, 16'h1502);
    cap(MODE_CAPTURE_RISE4, 2, 4, 16'h1603);
    cap(MODE_CAPTURE_RISE16, 5, 16, 16'h1704);
    port_capture();
    compares();
    second_unit();
    results();
  end
endmodule : capture_compare_unit_test

// ### verif/pin_partner.sv
// model of the outside world at the unit pin
// assumes: the pin is driven by the unit whenever its output enable is high
`timescale 1ns/1ps

module pin_partner
(
  input wire logic aclk,
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe,
  output logic unit_pin_in
);
  logic ext_level;

  initial ext_level = 1'b0;

  // wire level: unit drives when enabled, else the outside source
  assign unit_pin_in = unit_pin_oe ? unit_pin_out : ext_level;

  // pulses six cycles high and low, well above the synchroniser depth
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      ext_level <= 1'b1;
      repeat (6) @(posedge aclk);
      ext_level <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask : pulse
endmodule : pin_partner
